// >>> verilog/bsbe_pkg.sv
// Shared constants, operation codes and carrier structs for the skip, branch and bit execution unit.
package bsbe_pkg;

  // Widths of the program counter, branch offset, I/O address and register index.
  localparam int BSBE_PC_W = 12;
  localparam int BSBE_OFS_W = 7;
  localparam int BSBE_IO_W = 5;
  localparam int BSBE_RD_W = 5;

  // Bit positions of the flags inside the status register.
  localparam logic [2:0] BSBE_FLAG_C = 3'h0;
  localparam logic [2:0] BSBE_FLAG_Z = 3'h1;
  localparam logic [2:0] BSBE_FLAG_N = 3'h2;
  localparam logic [2:0] BSBE_FLAG_V = 3'h3;
  localparam logic [2:0] BSBE_FLAG_S = 3'h4;
  localparam logic [2:0] BSBE_FLAG_H = 3'h5;
  localparam logic [2:0] BSBE_FLAG_T = 3'h6;
  localparam logic [2:0] BSBE_FLAG_I = 3'h7;

  // Cycle costs of the operations.
  localparam logic [1:0] BSBE_COST_ONE = 2'h1;
  localparam logic [1:0] BSBE_COST_TWO = 2'h2;
  localparam logic [1:0] BSBE_COST_THREE = 2'h3;

  // Program counter advances for fall-through and the two skip lengths.
  localparam logic [BSBE_PC_W-1:0] BSBE_PC_STEP = 12'h001;
  localparam logic [BSBE_PC_W-1:0] BSBE_PC_SKIP_ONE = 12'h002;
  localparam logic [BSBE_PC_W-1:0] BSBE_PC_SKIP_TWO = 12'h003;

  // Reset values.
  localparam logic [7:0] BSBE_BYTE_RST = 8'h00;
  localparam logic [BSBE_PC_W-1:0] BSBE_PC_RST = 12'h000;

  // Operations this unit executes.
  typedef enum logic [3:0] {
    BSBE_OP_SKIP_REG_BIT_CLEAR = 4'h0,
    BSBE_OP_SKIP_REG_BIT_SET = 4'h1,
    BSBE_OP_SKIP_IO_BIT_CLEAR = 4'h2,
    BSBE_OP_SKIP_IO_BIT_SET = 4'h3,
    BSBE_OP_BRANCH_FLAG_SET = 4'h4,
    BSBE_OP_BRANCH_FLAG_CLEAR = 4'h5,
    BSBE_OP_IO_BIT_WRITE_ONE = 4'h6,
    BSBE_OP_IO_BIT_WRITE_ZERO = 4'h7,
    BSBE_OP_SHIFT_LEFT_LOGICAL = 4'h8,
    BSBE_OP_SHIFT_RIGHT_LOGICAL = 4'h9,
    BSBE_OP_ROTATE_LEFT_CARRY = 4'ha
  } bsbe_op_type;

  // One decoded instruction with its operands, as handed over by the core.
  typedef struct packed {
    bsbe_op_type op;
    logic [2:0] bit_sel;
    logic [BSBE_RD_W-1:0] rd_addr;
    logic [7:0] reg_val;
    logic [BSBE_IO_W-1:0] io_addr;
    logic [7:0] io_val;
    logic [BSBE_OFS_W-1:0] offset;
    logic [BSBE_PC_W-1:0] pc;
    logic next_two_words;
  } bsbe_req_type;

  // Write-back bundle toward the register file and I/O space.
  typedef struct packed {
    logic reg_we;
    logic [BSBE_RD_W-1:0] rd_addr;
    logic [7:0] reg_wdata;
    logic io_we;
    logic [BSBE_IO_W-1:0] io_addr;
    logic [7:0] io_wdata;
  } bsbe_wb_type;

endpackage

// >>> verilog/bsbe_flag_eval.sv
// Condition evaluator for the status-flag branches.
`timescale 1ns/10ps
`default_nettype none

module bsbe_flag_eval
(
  input wire logic [7:0] status_in,
  input wire logic [2:0] sel_in,
  input wire logic want_set_in,
  output logic taken_out
);

  import bsbe_pkg::*;

  // Value of the chosen flag; the sign position is rebuilt from N and V.
  logic flag_val;

  // Pick the flag, then compare it against the wanted polarity.
  always_comb
  begin
    case (sel_in)
      BSBE_FLAG_C: flag_val = status_in[BSBE_FLAG_C]; // [RULE8]
      BSBE_FLAG_Z: flag_val = status_in[BSBE_FLAG_Z]; // [RULE7]
      BSBE_FLAG_N: flag_val = status_in[BSBE_FLAG_N]; // [RULE9]
      BSBE_FLAG_V: flag_val = status_in[BSBE_FLAG_V]; // [RULE14]
      // Derived from N and V so a stale sign bit cannot mislead it.
      BSBE_FLAG_S: flag_val = status_in[BSBE_FLAG_N] ^ status_in[BSBE_FLAG_V]; // [RULE10] [RULE11]
      BSBE_FLAG_H: flag_val = status_in[BSBE_FLAG_H]; // [RULE12]
      BSBE_FLAG_T: flag_val = status_in[BSBE_FLAG_T]; // [RULE13]
      default: flag_val = status_in[BSBE_FLAG_I]; // [RULE15]
    endcase
    taken_out = want_set_in ? flag_val : ~flag_val; // [RULE5] [RULE6]
  end

endmodule

`default_nettype wire

// >>> verilog/bsbe_shift_unit.sv
// Shift and rotate datapath with its flag results.
`timescale 1ns/10ps
`default_nettype none

module bsbe_shift_unit
(
  input wire bsbe_pkg::bsbe_op_type op_in,
  input wire logic [7:0] value_in,
  input wire logic [7:0] status_in,
  output logic [7:0] result_out,
  output logic [7:0] status_out
);

  import bsbe_pkg::*;

  // Carry produced by the shifted-out bit.
  logic carry_new;

  // Shift the byte, then refresh Z, C, N and V; other flags pass through.
  always_comb
  begin
    case (op_in)
      BSBE_OP_SHIFT_RIGHT_LOGICAL:
      begin
        result_out = {1'b0, value_in[7:1]}; // [RULE19]
        carry_new = value_in[0];
      end
      BSBE_OP_ROTATE_LEFT_CARRY:
      begin
        result_out = {value_in[6:0], status_in[BSBE_FLAG_C]}; // [RULE20]
        carry_new = value_in[7];
      end
      default:
      begin
        result_out = {value_in[6:0], 1'b0}; // [RULE18]
        carry_new = value_in[7];
      end
    endcase
    status_out = status_in;
    status_out[BSBE_FLAG_C] = carry_new; // [RULE18] [RULE19] [RULE20]
    status_out[BSBE_FLAG_Z] = (result_out == BSBE_BYTE_RST);
    status_out[BSBE_FLAG_N] = result_out[7];
    status_out[BSBE_FLAG_V] = result_out[7] ^ carry_new;
  end

endmodule

`default_nettype wire

// >>> verilog/bsbe_exec.sv
// Execution unit for bit skips, flag branches, I/O bit writes and shifts.
//
// Function
// RULE1 - Register bit clear: skip next instruction.
// RULE2 - Register bit set: skip next, flags unchanged.
// RULE3 - I/O bit clear: skip, PC plus two/three.
// RULE4 - I/O bit set: skip, no flag change.
// RULE5 - Flag set branch: PC plus offset plus one.
// RULE6 - Flag clear branch: same arithmetic, else fall.
// RULE7 - Zero flag branches, set and clear.
// RULE8 - Carry branches, including same-or-higher and lower.
// RULE9 - Minus and plus branches test negative.
// RULE10 - Signed ge taken when N xor V zero.
// RULE11 - Signed lt taken when N xor V one.
// RULE12 - Half-carry branches, set and clear.
// RULE13 - Bit-copy flag branches, set and clear.
// RULE14 - Overflow flag branches, set and clear.
// RULE15 - Interrupt enable branches, set and clear.
// RULE16 - I/O bit write one, two cycles.
// RULE17 - I/O bit write zero, two cycles.
// RULE18 - Left shift, zero in, flags updated.
// RULE19 - Right shift, zero in, flags updated.
// RULE20 - Rotate left through carry, flags updated.
// RULE21 - Skip costs one, two or three cycles.
// RULE22 - Branch one/two cycles, signed word offset.
`timescale 1ns/10ps
`default_nettype none

module bsbe_exec
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic start_in,
  input wire bsbe_pkg::bsbe_req_type req_in,
  input wire logic [7:0] status_in,
  output logic busy_out,
  output logic done_out,
  output logic pc_load_out,
  output logic [bsbe_pkg::BSBE_PC_W-1:0] pc_out,
  output logic taken_out,
  output bsbe_pkg::bsbe_wb_type wb_out,
  output logic status_we_out,
  output logic [7:0] status_out
);

  import bsbe_pkg::*;

  // Sequencer states: idle waits for work, run counts out the cycle cost.
  // A single state bit is enough, since the counter carries the length.
  typedef enum logic [0:0] {
    BSBE_ST_IDLE = 1'b0,
    BSBE_ST_RUN = 1'b1
  } bsbe_state_type;

  // Sign-extends a word offset to program counter width.
  function automatic logic [BSBE_PC_W-1:0] sext_offset(input logic [BSBE_OFS_W-1:0] ofs);
    sext_offset = {{(BSBE_PC_W-BSBE_OFS_W){ofs[BSBE_OFS_W-1]}}, ofs};
  endfunction

  // Reads one bit of a byte by index.
  function automatic logic pick_bit(input logic [7:0] value, input logic [2:0] idx);
    pick_bit = value[idx];
  endfunction

  // Current sequencer state and its next value.
  bsbe_state_type state_reg;
  bsbe_state_type state_next;

  // Remaining cycles before the result is committed.
  logic [1:0] count_reg;

  // Results held while the instruction spends its extra cycles.
  logic [BSBE_PC_W-1:0] pend_pc_reg;
  logic pend_taken_reg;
  bsbe_wb_type pend_wb_reg;
  logic pend_status_we_reg;
  logic [7:0] pend_status_reg;

  // Combinational results of the instruction offered on req_in.
  logic [BSBE_PC_W-1:0] calc_pc;
  logic calc_taken;
  logic [1:0] calc_cost;
  bsbe_wb_type calc_wb;
  logic calc_status_we;
  logic [7:0] calc_status;

  // Outputs of the helper datapaths.
  logic branch_taken;
  logic [7:0] shift_result;
  logic [7:0] shift_status;

  // A request is accepted only when idle and the clock enable is high.
  // A start that arrives while busy is dropped, not queued, so the core must
  // hold the next instruction until it has seen done_out.
  logic accept;

  // The final cycle of a running instruction.
  logic finish;

  assign accept = clk_en_in && start_in && (state_reg == BSBE_ST_IDLE);
  assign finish = clk_en_in && (state_reg == BSBE_ST_RUN) && (count_reg == 2'h0);

  // Branch condition for the generic and named flag branches.
  bsbe_flag_eval u_flag_eval
  (
    .status_in(status_in),
    .sel_in(req_in.bit_sel),
    .want_set_in(req_in.op == BSBE_OP_BRANCH_FLAG_SET),
    .taken_out(branch_taken)
  );

  // Shift and rotate datapath.
  bsbe_shift_unit u_shift_unit
  (
    .op_in(req_in.op),
    .value_in(req_in.reg_val),
    .status_in(status_in),
    .result_out(shift_result),
    .status_out(shift_status)
  );

  // Work out the new program counter, cost and write-back for the offered request.
  always_comb
  begin
    // Defaults describe a one-cycle fall-through that writes nothing; each
    // branch of the case below overrides only what differs from that.
    calc_pc = req_in.pc + BSBE_PC_STEP;
    calc_taken = 1'b0;
    calc_cost = BSBE_COST_ONE;
    calc_wb = '0;
    calc_wb.rd_addr = req_in.rd_addr;
    calc_wb.io_addr = req_in.io_addr;
    calc_wb.io_wdata = req_in.io_val;
    calc_status_we = 1'b0;
    calc_status = status_in;
    case (req_in.op)
      BSBE_OP_SKIP_REG_BIT_CLEAR:
      begin
        calc_taken = ~pick_bit(req_in.reg_val, req_in.bit_sel); // [RULE1]
      end
      BSBE_OP_SKIP_REG_BIT_SET:
      begin
        calc_taken = pick_bit(req_in.reg_val, req_in.bit_sel); // [RULE2]
      end
      BSBE_OP_SKIP_IO_BIT_CLEAR:
      begin
        calc_taken = ~pick_bit(req_in.io_val, req_in.bit_sel); // [RULE3]
      end
      BSBE_OP_SKIP_IO_BIT_SET:
      begin
        calc_taken = pick_bit(req_in.io_val, req_in.bit_sel); // [RULE4]
      end
      BSBE_OP_BRANCH_FLAG_SET, BSBE_OP_BRANCH_FLAG_CLEAR:
      begin
        // Offset is a signed word count added on top of the one-word step.
        calc_taken = branch_taken;
        if (branch_taken)
        begin
          calc_pc = req_in.pc + sext_offset(req_in.offset) + BSBE_PC_STEP; // [RULE5] [RULE6] [RULE22]
          calc_cost = BSBE_COST_TWO; // [RULE22]
        end
      end
      BSBE_OP_IO_BIT_WRITE_ONE:
      begin
        // Read-modify-write of the addressed I/O byte; flags are left alone.
        calc_wb.io_we = 1'b1;
        calc_wb.io_wdata[req_in.bit_sel] = 1'b1; // [RULE16]
        calc_cost = BSBE_COST_TWO; // [RULE16]
      end
      BSBE_OP_IO_BIT_WRITE_ZERO:
      begin
        calc_wb.io_we = 1'b1;
        calc_wb.io_wdata[req_in.bit_sel] = 1'b0; // [RULE17]
        calc_cost = BSBE_COST_TWO; // [RULE17]
      end
      BSBE_OP_SHIFT_LEFT_LOGICAL, BSBE_OP_SHIFT_RIGHT_LOGICAL, BSBE_OP_ROTATE_LEFT_CARRY:
      begin
        calc_wb.reg_we = 1'b1;
        calc_wb.reg_wdata = shift_result; // [RULE18] [RULE19] [RULE20]
        calc_status_we = 1'b1;
        calc_status = shift_status;
      end
      default:
      begin
        // Codes outside the set simply fall through in one cycle.
        calc_taken = 1'b0;
      end
    endcase
    // Skips cover the length of the instruction being stepped over.
    // The four skip codes sit lowest in the op encoding, so one compare picks
    // them out; reordering the enum would silently break this test.
    if (calc_taken && (req_in.op <= BSBE_OP_SKIP_IO_BIT_SET))
    begin
      if (req_in.next_two_words)
      begin
        calc_pc = req_in.pc + BSBE_PC_SKIP_TWO; // [RULE1] [RULE3]
        calc_cost = BSBE_COST_THREE; // [RULE21]
      end
      else
      begin
        calc_pc = req_in.pc + BSBE_PC_SKIP_ONE; // [RULE2] [RULE4]
        calc_cost = BSBE_COST_TWO; // [RULE21]
      end
    end
  end

  // Next state of the sequencer.
  // The default arm recovers an impossible code by returning to idle.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      BSBE_ST_IDLE:
      begin
        if (accept)
        begin
          state_next = BSBE_ST_RUN;
        end
      end
      BSBE_ST_RUN:
      begin
        if (finish)
        begin
          state_next = BSBE_ST_IDLE;
        end
      end
      default:
      begin
        state_next = BSBE_ST_IDLE;
      end
    endcase
  end

  // State register; frozen while the clock enable is low.
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= BSBE_ST_IDLE;
    end
    else if (clk_en_in)
    begin
      state_reg <= state_next;
    end
  end

  // Cycle counter: loaded with cost minus one, so done lands cost cycles after start.
  // Two bits suffice because no operation of this unit costs more than three.
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count_reg <= 2'h0;
    end
    else if (accept)
    begin
      count_reg <= calc_cost - BSBE_COST_ONE; // [RULE21] [RULE22]
    end
    else if (clk_en_in && (state_reg == BSBE_ST_RUN) && (count_reg != 2'h0))
    begin
      count_reg <= count_reg - 2'h1;
    end
  end

  // Capture results at acceptance; operands may change after the start cycle.
  // Holding them here lets the core change req_in during the extra cycles.
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pend_pc_reg <= BSBE_PC_RST;
      pend_taken_reg <= 1'b0;
      pend_wb_reg <= '0;
      pend_status_we_reg <= 1'b0;
      pend_status_reg <= BSBE_BYTE_RST;
    end
    else if (accept)
    begin
      pend_pc_reg <= calc_pc;
      pend_taken_reg <= calc_taken;
      pend_wb_reg <= calc_wb;
      pend_status_we_reg <= calc_status_we; // [RULE2] [RULE4] [RULE12]
      pend_status_reg <= calc_status;
    end
  end

  // Busy flag, high from acceptance until the commit cycle begins.
  // It is registered from state_next so that it rises at the accepting edge itself.
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      busy_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      busy_out <= (state_next == BSBE_ST_RUN);
    end
  end

  // Commit pulses: one cycle of done, program counter load and write strobes.
  // The write-back data fields are copied on every enabled cycle, but only the
  // strobes mark them as new, so the far side must ignore them between commits.
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      done_out <= 1'b0;
      pc_load_out <= 1'b0;
      wb_out <= '0;
      status_we_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      // Strobes hold for exactly one enabled cycle.
      done_out <= finish;
      pc_load_out <= finish;
      wb_out <= pend_wb_reg;
      wb_out.reg_we <= finish && pend_wb_reg.reg_we;
      wb_out.io_we <= finish && pend_wb_reg.io_we; // [RULE16] [RULE17]
      status_we_out <= finish && pend_status_we_reg; // [RULE18]
    end
  end

  // Committed values, held steady between instructions.
  // Status is committed for every instruction; outside the shifts it echoes
  // the byte sampled at acceptance, which leaves the flags as they were.
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pc_out <= BSBE_PC_RST;
      taken_out <= 1'b0;
      status_out <= BSBE_BYTE_RST;
    end
    else if (finish)
    begin
      pc_out <= pend_pc_reg;
      taken_out <= pend_taken_reg;
      status_out <= pend_status_reg;
    end
  end

endmodule

`default_nettype wire

// >>> tb/bsbe_core_model.sv
// Program counter model of the core that sits beside the execution unit.
`timescale 1ns/10ps
`default_nettype none

module bsbe_core_model
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic pc_load_in,
  input wire logic [bsbe_pkg::BSBE_PC_W-1:0] pc_in,
  output logic [bsbe_pkg::BSBE_PC_W-1:0] pc_cur_out
);
  import bsbe_pkg::*;

  logic [BSBE_PC_W-1:0] pc_reg; // Program counter held by the core.

  // The core takes the new address at the edge that ends the commit cycle.
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pc_reg <= BSBE_PC_RST;
    else if (pc_load_in)
      pc_reg <= pc_in;
  end

  // Forwarding lets the next instruction issue in the commit cycle itself.
  assign pc_cur_out = pc_load_in ? pc_in : pc_reg;
endmodule

`default_nettype wire

// >>> tb/bsbe_exec_properties.sv
// Checker for the timing and results of the execution unit.
`timescale 1ns/10ps
`default_nettype none

module bsbe_exec_check
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic start_in,
  input wire bsbe_pkg::bsbe_req_type req_in,
  input wire logic [7:0] status_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic pc_load_out,
  input wire logic [bsbe_pkg::BSBE_PC_W-1:0] pc_out,
  input wire logic taken_out,
  input wire bsbe_pkg::bsbe_wb_type wb_out,
  input wire logic status_we_out,
  input wire logic [7:0] status_out
);
  import bsbe_pkg::*;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  logic cond_flag; // Selected flag; selector 4 is the signed test.
  logic [BSBE_PC_W-1:0] ofs_ext; // Offset widened with its sign.
  assign cond_flag = (req_in.bit_sel == BSBE_FLAG_S) ?
    (status_in[BSBE_FLAG_N] ^ status_in[BSBE_FLAG_V]) : status_in[req_in.bit_sel];
  assign ofs_ext = {{5{req_in.offset[6]}}, req_in.offset};

  // A request taken by an idle unit.
  sequence s_acc;
    start_in && clk_en_in && !busy_out;
  endsequence

  AST_ACCEPT: assert property (s_acc |=> busy_out)
    else $error("accepted request did not raise busy");
  AST_DONE_PULSE: assert property (done_out && clk_en_in |=> !done_out)
    else $error("done stood longer than one cycle");
  AST_PC_LOAD: assert property (done_out |-> pc_load_out && !busy_out)
    else $error("commit without program counter load");
  AST_STROBE: assert property ((wb_out.reg_we || wb_out.io_we || status_we_out) |-> done_out)
    else $error("write strobe outside commit");
  // Registered outputs set at edge N are first sampled at edge N plus one.
  AST_DONE_BOUND: assert property (s_acc |-> ##[2:4] done_out)
    else $error("instruction took more than three cycles");
  AST_BRANCH_TAKEN: assert property (s_acc ##0
    (req_in.op == BSBE_OP_BRANCH_FLAG_SET && cond_flag) |=> !done_out [*2] ##1
    (done_out && taken_out &&
    pc_out == $past(req_in.pc, 3) + $past(ofs_ext, 3) + 12'h001))
    else $error("taken branch wrong in target or timing");
  AST_BRANCH_FALL: assert property (s_acc ##0
    (req_in.op == BSBE_OP_BRANCH_FLAG_CLEAR && cond_flag) |=> !done_out ##1
    (done_out && !taken_out && pc_out == $past(req_in.pc, 2) + 12'h001))
    else $error("untaken branch wrong");
  AST_SKIP_TWO: assert property (s_acc ##0
    (req_in.op == BSBE_OP_SKIP_REG_BIT_SET && req_in.reg_val[req_in.bit_sel] &&
    req_in.next_two_words) |=> !done_out [*3] ##1
    (done_out && taken_out && pc_out == $past(req_in.pc, 4) + 12'h003))
    else $error("skip over two words wrong");
  AST_IO_ZERO: assert property (s_acc ##0
    (req_in.op == BSBE_OP_IO_BIT_WRITE_ZERO) |-> ##3 (wb_out.io_we && wb_out.io_wdata ==
    ($past(req_in.io_val, 3) & ~(8'h01 << $past(req_in.bit_sel, 3)))))
    else $error("bit clear wrote wrong byte");
  AST_SHIFT_LEFT: assert property (s_acc ##0
    (req_in.op == BSBE_OP_SHIFT_LEFT_LOGICAL) |=> ##1 (wb_out.reg_we &&
    wb_out.reg_wdata == {$past(req_in.reg_val[6:0], 2), 1'b0} &&
    status_out[BSBE_FLAG_C] == $past(req_in.reg_val[7], 2)))
    else $error("left shift result wrong");
  AST_FREEZE: assert property (!clk_en_in |=> $stable(busy_out) && $stable(done_out) &&
    $stable(pc_out) && $stable(wb_out))
    else $error("outputs moved while the clock enable was low");
endmodule

bind bsbe_exec bsbe_exec_check u_check (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .clk_en_in(clk_en_in), .start_in(start_in), .req_in(req_in), .status_in(status_in),
  .busy_out(busy_out), .done_out(done_out), .pc_load_out(pc_load_out), .pc_out(pc_out),
  .taken_out(taken_out), .wb_out(wb_out), .status_we_out(status_we_out),
  .status_out(status_out));

`default_nettype wire

// >>> tb/test_bsbe_exec.sv
// Self-checking bench for the skip, branch and bit execution unit.
`timescale 1ns/10ps
`default_nettype none

module test_bsbe_exec;
  import bsbe_pkg::*;

  // One expected commit: kind 0 skip or branch, 1 I/O bit write, 2 shift.
  typedef struct {int kind; int cost; int t0; logic [11:0] pc; logic tk;
    logic [7:0] data; logic [7:0] st; logic [4:0] ad;} bsbe_exp_type;

  logic ref_clk_in, rst_n_in, clk_en_in, start_in, busy_out, done_out, pc_load_out;
  logic taken_out, status_we_out;
  logic [7:0] status_in, status_out;
  logic [BSBE_PC_W-1:0] pc_out, pc_cur;
  bsbe_req_type req_in;
  bsbe_wb_type wb_out;
  int err_count, n_compared, cyc;
  integer seed;
  bsbe_exp_type exp_q[$]; // Notes from the driver, oldest first.

  bsbe_exec DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
    .start_in(start_in), .req_in(req_in), .status_in(status_in), .busy_out(busy_out),
    .done_out(done_out), .pc_load_out(pc_load_out), .pc_out(pc_out), .taken_out(taken_out),
    .wb_out(wb_out), .status_we_out(status_we_out), .status_out(status_out));
  bsbe_core_model u_model (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .pc_load_in(pc_load_out), .pc_in(pc_out), .pc_cur_out(pc_cur));

  initial
  begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  // Cycle count lets the monitor measure each instruction's cost.
  always @(posedge ref_clk_in) cyc <= cyc + 1;

  task automatic results;
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(logic [15:0] got, logic [15:0] want);
    n_compared++;
    if (got !== want)
    begin
      err_count++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  // Issues one instruction with random operands and notes what must come back.
  task automatic issue(bsbe_op_type op, logic [2:0] b, logic [6:0] ofs);
    bsbe_exp_type e;
    logic f, c, hold;
    logic [7:0] r;
    int k;
    req_in = '{op: op, bit_sel: b, offset: ofs, pc: pc_cur, rd_addr: 5'($random(seed)),
      reg_val: 8'($random(seed)), io_addr: 5'($random(seed)), io_val: 8'($random(seed)),
      next_two_words: 1'($random(seed))};
    status_in = 8'($random(seed));
    hold = 1'($random(seed));
    f = (b == BSBE_FLAG_S) ? status_in[BSBE_FLAG_N] ^ status_in[BSBE_FLAG_V] : status_in[b];
    e = '{kind: 0, cost: 1, t0: 0, pc: pc_cur + 12'h001, tk: 1'b0, data: 8'h00, st: status_in,
      ad: req_in.io_addr};
    case (op)
      BSBE_OP_SKIP_REG_BIT_CLEAR: e.tk = !req_in.reg_val[b];
      BSBE_OP_SKIP_REG_BIT_SET: e.tk = req_in.reg_val[b];
      BSBE_OP_SKIP_IO_BIT_CLEAR: e.tk = !req_in.io_val[b];
      BSBE_OP_SKIP_IO_BIT_SET: e.tk = req_in.io_val[b];
      BSBE_OP_BRANCH_FLAG_SET: e.tk = f;
      BSBE_OP_BRANCH_FLAG_CLEAR: e.tk = !f;
      BSBE_OP_IO_BIT_WRITE_ONE: e.data = req_in.io_val | (8'h01 << b);
      BSBE_OP_IO_BIT_WRITE_ZERO: e.data = req_in.io_val & ~(8'h01 << b);
      BSBE_OP_SHIFT_LEFT_LOGICAL, BSBE_OP_SHIFT_RIGHT_LOGICAL,
        BSBE_OP_ROTATE_LEFT_CARRY: e.kind = 2;
      default: e.tk = 1'b0; // Unknown codes fall through in one cycle.
    endcase
    r = {req_in.reg_val[6:0], (op == BSBE_OP_ROTATE_LEFT_CARRY) & status_in[BSBE_FLAG_C]};
    c = req_in.reg_val[7];
    if (op == BSBE_OP_SHIFT_RIGHT_LOGICAL)
    begin
      r = {1'b0, req_in.reg_val[7:1]};
      c = req_in.reg_val[0];
    end
    if (op < BSBE_OP_BRANCH_FLAG_SET)
      e.cost = e.tk ? (req_in.next_two_words ? 3 : 2) : 1;
    else if (op < BSBE_OP_IO_BIT_WRITE_ONE)
      e.cost = e.tk ? 2 : 1;
    else if (op < BSBE_OP_SHIFT_LEFT_LOGICAL)
    begin
      e.kind = 1;
      e.cost = 2;
    end
    if (e.kind == 0 && e.tk)
      e.pc = (op < BSBE_OP_BRANCH_FLAG_SET) ? pc_cur + 12'(e.cost) :
        pc_cur + {{5{ofs[6]}}, ofs} + 12'h001;
    if (e.kind == 2)
    begin
      e.data = r;
      e.ad = req_in.rd_addr;
      e.st[BSBE_FLAG_C] = c;
      e.st[BSBE_FLAG_Z] = (r == 8'h00);
      e.st[BSBE_FLAG_N] = r[7];
      e.st[BSBE_FLAG_V] = r[7] ^ c;
    end
    start_in = 1'b1;
    @(posedge ref_clk_in);
    #1;
    e.t0 = cyc;
    exp_q.push_back(e);
    // Holding the strobe one more edge is a request while busy, to be ignored.
    if (hold)
    begin
      @(posedge ref_clk_in);
      #1;
    end
    start_in = 1'b0;
    for (k = 0; k < 8 && done_out !== 1'b1; k++)
    begin
      @(posedge ref_clk_in);
      #1;
    end
    if (k == 8)
    begin
      err_count++;
      results();
    end
    if (hold)
    begin
      @(posedge ref_clk_in);
      #1;
    end
  endtask

  // Monitor: every commit takes the oldest note and compares against it.
  always @(negedge ref_clk_in)
  begin
    bsbe_exp_type e;
    int sw; // Expected strobes: status write, register write, I/O write.
    if (done_out === 1'b1 && exp_q.size() == 0)
      check(16'h0001, 16'h0000);
    else if (done_out === 1'b1)
    begin
      e = exp_q.pop_front();
      check(16'(cyc - e.t0), 16'(e.cost));
      check(16'(pc_out), 16'(e.pc));
      if (e.kind == 0)
        check(16'(taken_out), 16'(e.tk));
      sw = (e.kind == 2) ? 6 : e.kind;
      check(16'({status_we_out, wb_out.reg_we, wb_out.io_we}), 16'(sw));
      if (e.kind != 2)
        check(16'(status_out), 16'(e.st));
      if (e.kind != 0)
        check(16'(e.kind == 1 ? wb_out.io_addr : wb_out.rd_addr), 16'(e.ad));
      if (e.kind == 1)
        check({7'h00, wb_out.io_we, wb_out.io_wdata}, {8'h01, e.data});
      if (e.kind == 2)
        check({wb_out.reg_wdata, status_out}, {e.data, e.st});
    end
  end

  initial
  begin
    seed = 32'hd240a292;
    rst_n_in = 1'b0;
    clk_en_in = 1'b1;
    start_in = 1'b0;
    req_in = '0;
    status_in = 8'h00;
    err_count = 0;
    n_compared = 0;
    cyc = 0;
    repeat (10) @(posedge ref_clk_in);
    #1;
    rst_n_in = 1'b1;
    // Every operation and one unused code against every selector, several rounds.
    for (int n = 0; n < 4; n++)
      for (int o = 0; o <= 11; o++)
        for (int b = 0; b < 8; b++)
          issue(bsbe_op_type'(4'(o)), 3'(b), 7'($random(seed)));
    // Largest backward and forward offsets.
    for (int b = 0; b < 8; b++)
    begin
      issue(BSBE_OP_BRANCH_FLAG_SET, 3'(b), 7'h40);
      issue(BSBE_OP_BRANCH_FLAG_CLEAR, 3'(b), 7'h3f);
    end
    // With the clock enable low even an idle unit must not take a request.
    @(posedge ref_clk_in);
    #1;
    clk_en_in = 1'b0;
    start_in = 1'b1;
    repeat (3) @(posedge ref_clk_in);
    #1;
    check(16'({busy_out, done_out}), 16'h0000);
    clk_en_in = 1'b1;
    start_in = 1'b0;
    repeat (4) @(posedge ref_clk_in);
    check(16'(exp_q.size()), 16'h0000);
    results();
  end
endmodule

`default_nettype wire
